// *** logic/pcf_pkg.sv ***
// constants for the pll configuration and clock flag block
package pcf_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PCF_OFS_MULT = 8'h34;
  localparam logic [7:0] PCF_OFS_REF_DIVIDER_VALUE = 8'h35;
  localparam logic [7:0] PCF_OFS_POST_DIVIDER_VALUE = 8'h36;
  localparam logic [7:0] PCF_OFS_FLAGS = 8'h37;
  localparam logic [7:0] PCF_OFS_IRQEN = 8'h38;
  localparam logic [7:0] PCF_OFS_CLKSEL = 8'h39;
  localparam logic [7:0] PCF_OFS_WRITE_PROTECT_BIT = 8'h3a;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PCF_RST_MULT = 8'h00;
  localparam logic [7:0] PCF_RST_REF_DIVIDER_VALUE = 8'h0f;
  localparam logic [4:0] PCF_RST_POST_DIVIDER_VALUE = 5'h03;
  localparam logic [2:0] PCF_RST_IRQEN = 3'h0;
  localparam logic PCF_RST_CLKSEL = 1'b1;
  localparam logic PCF_RST_WRITE_PROTECT_BIT = 1'b0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PCF_RANGE_HI = 7;
  localparam int PCF_RANGE_LO = 6;
  localparam int PCF_MULT_HI = 5;
  localparam int PCF_REF_DIVIDER_VALUE_HI = 3;
  localparam int PCF_POST_DIVIDER_VALUE_HI = 4;
  localparam int PCF_FLG_TICK = 7;
  localparam int PCF_FLG_POR = 6;
  localparam int PCF_FLG_LVR = 5;
  localparam int PCF_FLG_SETTLE = 4;
  localparam int PCF_FLG_LOCK = 3;
  localparam int PCF_FLG_ILLEGAL_ADDRESS_RESET_FLAG = 2;
  localparam int PCF_FLG_OSCCHG = 1;
  localparam int PCF_FLG_OSCQ = 0;
  localparam int PCF_IRQ_TICK = 7;
  localparam int PCF_IRQ_SETTLE = 4;
  localparam int PCF_IRQ_OSC = 1;
  localparam int PCF_CLKSEL_BIT = 7;
  localparam int PCF_WRITE_PROTECT_BIT_BIT = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PCF_CLK_PERIOD_NS = 10;
  localparam int PCF_IRC_PERIOD_NS = 1000;
  localparam int PCF_IRC_CYCLES = PCF_IRC_PERIOD_NS / PCF_CLK_PERIOD_NS;
  localparam logic [6:0] PCF_IRC_LAST = 7'(PCF_IRC_CYCLES - 1);
  localparam logic [1:0] PCF_INT_REF_RANGE = 2'h0;
  localparam int PCF_VCO_REF_FACTOR_SHIFT = 1;
  localparam int PCF_WIN_SHIFT = 3;
  localparam logic [3:0] PCF_WIN_LAST = 4'((1 << PCF_WIN_SHIFT) - 1);
  localparam logic [11:0] PCF_LOCK_TOL = 12'h004;
  localparam logic [1:0] PCF_LOCK_STABLE = 2'h2;
  localparam logic [11:0] PCF_OSC_MIN_TICKS = 12'h004;
  localparam logic [4:0] PCF_UNLOCK_DIV = 5'h03;
endpackage : pcf_pkg

// *** logic/pcf_top.sv ***
// pll configuration registers, lock and oscillator qualification, clock flags
//
// Local design decision: strobed register access.
`timescale 1ns/1ns

// Notes on behaviour
// R01: pll config writes need unprotected and pll select
// R02: accepted config write clears lock and qualified
// R03: locked vco equals twice reference times multiplier+1
// R04: software picks vco range 00 or 01 only
// R05: reference is osc over divider+1, else internal
// R06: internal reference forces fixed filter range
// R07: software picks reference range by reference frequency
// R08: post divider write needs pll select set
// R09: pll output vco over post+1, unlocked over 4
// R10: bus clock is half of selected source
// R11: tick flag sets per tick, write one clears
// R12: power-on flag survives system reset, write clears
// R13: low-voltage flag set by lvr and power-on
// R14: illegal-address flag, cleared by power-on or write one
// R15: lock change flag sets on any lock change
// R16: lock status read-only, within tolerance means one; code sets it only after two windows in a row within tolerance
// R17: osc change flag sets on qualified change
// R18: qualified bit gates can osc clock, full stop clears
// R19: qualification counts osc against reference-tick window
// R20: lock loss clears qualified unless pseudo stop
// R21: enabled set flags request an interrupt
// R22: pll select forced on unqualified or full stop
// R23: lock by windowed vco count with tolerance
module pcf_top
  import pcf_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic sys_reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic ext_osc_enable_in,
  input wire logic osc_tick_in,
  input wire logic vco_tick_in,
  input wire logic periodic_tick_in,
  input wire logic full_stop_entry_in,
  input wire logic pseudo_stop_in,
  input wire logic lvr_event_in,
  input wire logic illegal_address_reset_flag_event_in,
  output logic [7:0] rd_data_out,
  output logic lock_out,
  output logic osc_qualified_out,
  output logic pll_source_select_out,
  output logic [1:0] vco_range_sel_out,
  output logic [1:0] ref_range_sel_out,
  output logic pll_clk_en_out,
  output logic bus_clk_en_out,
  output logic can_osc_en_out,
  output logic irq_req_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mult;
    logic [7:0] ref_divider_value;
    logic [4:0] post;
    logic [2:0] irq_en;
    logic clksel;
    logic write_protect_bit;
    logic tick_flag;
    logic power_on_reset_flag;
    logic low_voltage_reset_flag;
    logic settle_change_flag;
    logic illegal_address_reset_flag;
    logic osc_change_flag;
    logic lock;
    logic osc_qualified;
    logic [3:0] ref_div_cnt;
    logic [6:0] irc_cnt;
    logic [4:0] post_cnt;
    logic bus_ph;
    logic [3:0] win_cnt;
    logic [11:0] vco_cnt;
    logic [11:0] osc_cnt;
    logic [1:0] stable_cnt;
    logic [1:0] ref_filter;
    logic [7:0] rd_data;
    logic pll_en;
    logic bus_en;
    logic can_en;
    logic irq;
  } pcf_state_s;

  localparam pcf_state_s PCF_RST_STATE = '{
    mult: PCF_RST_MULT,
    ref_divider_value: PCF_RST_REF_DIVIDER_VALUE,
    post: PCF_RST_POST_DIVIDER_VALUE,
    irq_en: PCF_RST_IRQEN,
    clksel: PCF_RST_CLKSEL,
    write_protect_bit: PCF_RST_WRITE_PROTECT_BIT,
    power_on_reset_flag: 1'b1,
    low_voltage_reset_flag: 1'b1,
    default: '0
  };

  pcf_state_s state_ff;
  pcf_state_s nxt_state;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // set wins over a write-one clear in the same cycle
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    pcf_state_s n;
    pcf_state_s keep;
    logic cfg_ok;
    logic acc_mult;
    logic acc_ref;
    logic acc_post;
    logic flg_wr;
    logic ref_tick;
    logic win_end;
    logic match;
    logic [6:0] mult_p1;
    logic [11:0] expected;
    logic [11:0] diff;
    logic [4:0] div_sel;
    logic pll_tick;
    logic src_tick;
    logic [7:0] rmux;
    n = state_ff;
    keep = PCF_RST_STATE;
    // R01: config write gating
    cfg_ok = ~state_ff.write_protect_bit & state_ff.clksel;
    acc_mult = wr_en_in & hit(addr_in, PCF_OFS_MULT) & cfg_ok;
    acc_ref = wr_en_in & hit(addr_in, PCF_OFS_REF_DIVIDER_VALUE) & cfg_ok;
    // R08: post divider needs pll select
    acc_post = wr_en_in & hit(addr_in, PCF_OFS_POST_DIVIDER_VALUE) & state_ff.clksel;
    flg_wr = wr_en_in & hit(addr_in, PCF_OFS_FLAGS);
    if (acc_mult) begin
      n.mult = wr_data_in;
    end
    if (acc_ref) begin
      n.ref_divider_value = {wr_data_in[PCF_RANGE_HI:PCF_RANGE_LO], 2'h0, wr_data_in[PCF_REF_DIVIDER_VALUE_HI:0]};
    end
    if (acc_post) begin
      n.post = wr_data_in[PCF_POST_DIVIDER_VALUE_HI:0];
    end
    if (wr_en_in && hit(addr_in, PCF_OFS_IRQEN)) begin
      n.irq_en = {wr_data_in[PCF_IRQ_TICK], wr_data_in[PCF_IRQ_SETTLE], wr_data_in[PCF_IRQ_OSC]};
    end
    if (wr_en_in && hit(addr_in, PCF_OFS_WRITE_PROTECT_BIT)) begin
      n.write_protect_bit = wr_data_in[PCF_WRITE_PROTECT_BIT_BIT];
    end

    // R05: reference tick source and divider
    ref_tick = 1'b0;
    if (ext_osc_enable_in) begin
      n.irc_cnt = '0;
      if (osc_tick_in) begin
        if (state_ff.ref_div_cnt >= state_ff.ref_divider_value[PCF_REF_DIVIDER_VALUE_HI:0]) begin
          n.ref_div_cnt = '0;
          ref_tick = 1'b1;
        end else begin
          n.ref_div_cnt = state_ff.ref_div_cnt + 4'h1;
        end
      end
    end else begin
      n.ref_div_cnt = '0;
      if (state_ff.irc_cnt == PCF_IRC_LAST) begin
        n.irc_cnt = '0;
        ref_tick = 1'b1;
      end else begin
        n.irc_cnt = state_ff.irc_cnt + 7'h01;
      end
    end

    // R06: filter range fixed on internal reference
    n.ref_filter = ext_osc_enable_in ? state_ff.ref_divider_value[PCF_RANGE_HI:PCF_RANGE_LO] : PCF_INT_REF_RANGE;

    // R03: expected vco count per window
    mult_p1 = {1'b0, state_ff.mult[PCF_MULT_HI:0]} + 7'h01;
    expected = 12'({5'h00, mult_p1} << (PCF_WIN_SHIFT + PCF_VCO_REF_FACTOR_SHIFT));
    diff = (state_ff.vco_cnt >= expected) ? state_ff.vco_cnt - expected : expected - state_ff.vco_cnt;
    match = (diff <= PCF_LOCK_TOL);

    // R19: osc counted against reference-tick window
    if (vco_tick_in && state_ff.vco_cnt != 12'hfff) begin
      n.vco_cnt = state_ff.vco_cnt + 12'h001;
    end
    if (osc_tick_in && state_ff.osc_cnt != 12'hfff) begin
      n.osc_cnt = state_ff.osc_cnt + 12'h001;
    end
    win_end = ref_tick & (state_ff.win_cnt == PCF_WIN_LAST);
    if (ref_tick) begin
      n.win_cnt = state_ff.win_cnt + 4'h1;
    end
    // R23: windowed lock detection
    // R16: lock follows tolerance
    if (win_end) begin
      n.win_cnt = '0;
      n.vco_cnt = '0;
      n.osc_cnt = '0;
      if (match) begin
        if (state_ff.stable_cnt != PCF_LOCK_STABLE) begin
          n.stable_cnt = state_ff.stable_cnt + 2'h1;
        end
        n.lock = (n.stable_cnt == PCF_LOCK_STABLE);
      end else begin
        n.stable_cnt = '0;
        n.lock = 1'b0;
      end
      // R20: pseudo stop keeps qualification
      n.osc_qualified = (n.lock | (pseudo_stop_in & state_ff.osc_qualified)) & ext_osc_enable_in &
                        (state_ff.osc_cnt >= PCF_OSC_MIN_TICKS);
    end
    // R20: lock loss drops qualification
    if (state_ff.lock && !n.lock && !pseudo_stop_in) begin
      n.osc_qualified = 1'b0;
    end
    // R02: reconfiguration restarts detection
    if (acc_mult || acc_ref) begin
      n.lock = 1'b0;
      n.osc_qualified = 1'b0;
      n.stable_cnt = '0;
      n.win_cnt = '0;
      n.vco_cnt = '0;
      n.osc_cnt = '0;
    end
    // R18: full stop clears qualification
    if (full_stop_entry_in) begin
      n.osc_qualified = 1'b0;
    end

    // R22: pll select write and forcing
    if (wr_en_in && hit(addr_in, PCF_OFS_CLKSEL) && !state_ff.write_protect_bit) begin
      n.clksel = wr_data_in[PCF_CLKSEL_BIT] | ~state_ff.osc_qualified;
    end
    if (!n.osc_qualified || full_stop_entry_in) begin
      n.clksel = 1'b1;
    end

    // R11: tick flag
    n.tick_flag = flag_next(state_ff.tick_flag, periodic_tick_in, flg_wr & wr_data_in[PCF_FLG_TICK]);
    // R12: power-on flag cleared by software only
    n.power_on_reset_flag = flag_next(state_ff.power_on_reset_flag, 1'b0, flg_wr & wr_data_in[PCF_FLG_POR]);
    // R13: low-voltage flag
    n.low_voltage_reset_flag = flag_next(state_ff.low_voltage_reset_flag, lvr_event_in,
                                         flg_wr & wr_data_in[PCF_FLG_LVR]);
    // R14: illegal-address flag
    n.illegal_address_reset_flag = flag_next(state_ff.illegal_address_reset_flag, illegal_address_reset_flag_event_in,
                                             flg_wr & wr_data_in[PCF_FLG_ILLEGAL_ADDRESS_RESET_FLAG]);
    // R15: lock change flag
    n.settle_change_flag = flag_next(state_ff.settle_change_flag, n.lock ^ state_ff.lock,
                                     flg_wr & wr_data_in[PCF_FLG_SETTLE]);
    // R17: qualified change flag
    n.osc_change_flag = flag_next(state_ff.osc_change_flag, n.osc_qualified ^ state_ff.osc_qualified,
                                  flg_wr & wr_data_in[PCF_FLG_OSCCHG]);

    // R09: pll output divider
    div_sel = state_ff.lock ? state_ff.post : PCF_UNLOCK_DIV;
    pll_tick = 1'b0;
    if (vco_tick_in) begin
      if (state_ff.post_cnt >= div_sel) begin
        n.post_cnt = '0;
        pll_tick = 1'b1;
      end else begin
        n.post_cnt = state_ff.post_cnt + 5'h01;
      end
    end
    n.pll_en = pll_tick;
    // R10: bus clock halves the selected source
    src_tick = state_ff.clksel ? pll_tick : osc_tick_in;
    if (src_tick) begin
      n.bus_ph = ~state_ff.bus_ph;
    end
    n.bus_en = src_tick & state_ff.bus_ph;
    // R18: can osc clock gated by qualification
    n.can_en = osc_tick_in & state_ff.osc_qualified;
    // R21: enabled flags request interrupt
    n.irq = (n.tick_flag & n.irq_en[2]) | (n.settle_change_flag & n.irq_en[1]) |
            (n.osc_change_flag & n.irq_en[0]);

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    rmux = 8'h00;
    unique case (addr_in)
      PCF_OFS_MULT: rmux = state_ff.mult;
      PCF_OFS_REF_DIVIDER_VALUE: rmux = state_ff.ref_divider_value;
      PCF_OFS_POST_DIVIDER_VALUE: rmux = {3'h0, state_ff.post};
      PCF_OFS_FLAGS: rmux = {state_ff.tick_flag, state_ff.power_on_reset_flag,
                             state_ff.low_voltage_reset_flag, state_ff.settle_change_flag,
                             state_ff.lock, state_ff.illegal_address_reset_flag,
                             state_ff.osc_change_flag, state_ff.osc_qualified};
      PCF_OFS_IRQEN: rmux = {state_ff.irq_en[2], 2'h0, state_ff.irq_en[1], 2'h0, state_ff.irq_en[0], 1'b0};
      PCF_OFS_CLKSEL: rmux = {state_ff.clksel, 7'h00};
      PCF_OFS_WRITE_PROTECT_BIT: rmux = {7'h00, state_ff.write_protect_bit};
      default: rmux = 8'h00;
    endcase
    n.rd_data = rd_en_in ? rmux : 8'h00;

    // system reset keeps the reset-cause flags
    if (sys_reset_in) begin
      keep.power_on_reset_flag = n.power_on_reset_flag;
      keep.low_voltage_reset_flag = n.low_voltage_reset_flag;
      keep.illegal_address_reset_flag = n.illegal_address_reset_flag;
      n = keep;
    end
    nxt_state = n;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // R12: power-on reset sets power-on and low-voltage flags
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= PCF_RST_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data_out = state_ff.rd_data;
  assign lock_out = state_ff.lock;
  assign osc_qualified_out = state_ff.osc_qualified;
  assign pll_source_select_out = state_ff.clksel;
  assign vco_range_sel_out = state_ff.mult[PCF_RANGE_HI:PCF_RANGE_LO];
  assign ref_range_sel_out = state_ff.ref_filter;
  assign pll_clk_en_out = state_ff.pll_en;
  assign bus_clk_en_out = state_ff.bus_en;
  assign can_osc_en_out = state_ff.can_en;
  assign irq_req_out = state_ff.irq;

endmodule : pcf_top

// *** testbench/pcf_top_assertions.sv ***
// checker for the pll configuration and clock flag block
`timescale 1ns/1ns
module pcf_top_assertions
  import pcf_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic sys_reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic ext_osc_enable_in,
  input wire logic osc_tick_in,
  input wire logic full_stop_entry_in,
  input wire logic pseudo_stop_in,
  input wire logic lock_out,
  input wire logic osc_qualified_out,
  input wire logic pll_source_select_out,
  input wire logic [1:0] vco_range_sel_out,
  input wire logic [1:0] ref_range_sel_out,
  input wire logic can_osc_en_out
);
  // ----------------------------------------
  // protect bit shadow
  // ----------------------------------------
  logic write_protect_bit_ff;
  logic mult_wr;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      write_protect_bit_ff <= PCF_RST_WRITE_PROTECT_BIT;
    end else if (sys_reset_in) begin
      write_protect_bit_ff <= PCF_RST_WRITE_PROTECT_BIT;
    end else if (wr_en_in && addr_in == PCF_OFS_WRITE_PROTECT_BIT) begin
      write_protect_bit_ff <= wr_data_in[PCF_WRITE_PROTECT_BIT_BIT];
    end
  end
  assign mult_wr = wr_en_in && !sys_reset_in && addr_in == PCF_OFS_MULT;

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence take_s; mult_wr && !write_protect_bit_ff && pll_source_select_out; endsequence
  sequence skip_s; mult_wr && (write_protect_bit_ff || !pll_source_select_out); endsequence
  sequence unqual_s; !osc_qualified_out [*2]; endsequence
  sequence int_ref_s; !ext_osc_enable_in [*3]; endsequence

  AST_MULT_TAKE:
    assert property (take_s |=> !lock_out && !osc_qualified_out && vco_range_sel_out == $past(wr_data_in[7:6]))
      else $error("accepted multiplier write not applied");
  AST_MULT_SKIP:
    assert property (skip_s |=> $stable(vco_range_sel_out))
      else $error("refused multiplier write changed range");
  AST_CAN_GATED:
    assert property (unqual_s |-> !can_osc_en_out)
      else $error("can clock enable while unqualified");
  AST_CAN_TICK:
    assert property (can_osc_en_out |-> $past(osc_tick_in))
      else $error("can clock enable without osc tick");
  AST_SEL_FORCED:
    assert property (unqual_s |-> pll_source_select_out)
      else $error("pll select not forced while unqualified");
  AST_FULL_STOP:
    assert property (full_stop_entry_in |=> !osc_qualified_out ##1 pll_source_select_out)
      else $error("full stop entry did not clear qualified");
  AST_LOCK_LOSS:
    assert property ($fell(lock_out) && !pseudo_stop_in && !$past(pseudo_stop_in) |-> ##[0:1] !osc_qualified_out)
      else $error("lock loss kept qualified");
  AST_REF_INT:
    assert property (int_ref_s |-> ref_range_sel_out == PCF_INT_REF_RANGE)
      else $error("reference range not fixed on internal osc");
endmodule : pcf_top_assertions

bind pcf_top pcf_top_assertions u_pcf_chk (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sys_reset_in(sys_reset_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .ext_osc_enable_in(ext_osc_enable_in), .osc_tick_in(osc_tick_in),
  .full_stop_entry_in(full_stop_entry_in), .pseudo_stop_in(pseudo_stop_in), .lock_out(lock_out),
  .osc_qualified_out(osc_qualified_out), .pll_source_select_out(pll_source_select_out),
  .vco_range_sel_out(vco_range_sel_out), .ref_range_sel_out(ref_range_sel_out), .can_osc_en_out(can_osc_en_out)
);

// *** testbench/tb.sv ***
// self-checking bench for the pll configuration and clock flag block
`timescale 1ns/1ns
module tb
  import pcf_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic ext_osc_enable_in = 1'b0;
  logic osc_tick_in = 1'b0;
  logic vco_tick_in = 1'b0;
  logic pseudo_stop_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wr_data_in = 8'h00;
  logic [4:0] evt = 5'h00;
  logic [7:0] rd_data_out;
  logic [1:0] vco_range_sel_out;
  logic [1:0] ref_range_sel_out;
  logic lock_out, osc_qualified_out, pll_source_select_out, pll_clk_en_out, bus_clk_en_out, can_osc_en_out;
  logic irq_req_out;
  logic [31:0] seed = 32'h09ce3027;
  logic [31:0] r;
  logic [7:0] m_e, r_e, p_e;
  int errors = 0;
  int n_checks = 0;
  int vco_p = 0;
  int osc_p = 0;
  int vc = 0;
  int oc = 0;
  int np = 0;
  int nb = 0;
  int nc = 0;

  pcf_top dut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sys_reset_in(evt[4]), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .ext_osc_enable_in(ext_osc_enable_in), .osc_tick_in(osc_tick_in),
    .vco_tick_in(vco_tick_in), .periodic_tick_in(evt[2]), .full_stop_entry_in(evt[3]),
    .pseudo_stop_in(pseudo_stop_in),
    .lvr_event_in(evt[1]), .illegal_address_reset_flag_event_in(evt[0]), .rd_data_out(rd_data_out), .lock_out(lock_out),
    .osc_qualified_out(osc_qualified_out), .pll_source_select_out(pll_source_select_out),
    .vco_range_sel_out(vco_range_sel_out), .ref_range_sel_out(ref_range_sel_out), .pll_clk_en_out(pll_clk_en_out),
    .bus_clk_en_out(bus_clk_en_out), .can_osc_en_out(can_osc_en_out), .irq_req_out(irq_req_out)
  );

  // ----------------------------------------
  // clock, osc and vco ticks, pulse counters
  // ----------------------------------------
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    vc = (vco_p == 0) ? 0 : (vc + 1) % vco_p;
    oc = (osc_p == 0) ? 0 : (oc + 1) % osc_p;
    vco_tick_in <= vco_p != 0 && vc == 0;
    osc_tick_in <= osc_p != 0 && oc == 0;
  end
  always @(negedge ref_clk_in) begin
    np += int'(pll_clk_en_out === 1'b1);
    nb += int'(bus_clk_en_out === 1'b1);
    nc += int'(can_osc_en_out === 1'b1);
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [7:0] upd(input logic [7:0] o, input logic [7:0] n, input logic [7:0] m, input logic ok);
    return ok ? (n & m) : o;
  endfunction : upd
  task results();
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= v;
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
  endtask : wr
  task rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge ref_clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_en_in <= 1'b0;
    #1;
    chk(rd_data_out & m, e);
  endtask : rdc
  task ev(input logic [4:0] m);
    @(posedge ref_clk_in);
    evt <= m;
    @(posedge ref_clk_in);
    evt <= 5'h00;
  endtask : ev
  task settle();
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask : settle
  task wlk(input logic q);
    int i;
    @(negedge ref_clk_in);
    for (i = 0; i < 9000 && !(lock_out === 1'b1 && (q === 1'b0 || osc_qualified_out === 1'b1)); i++) begin
      @(negedge ref_clk_in);
    end
    if (i == 9000) begin
      errors++;
      results();
    end
  endtask : wlk
  task rate(input int div);
    np = 0;
    nb = 0;
    repeat (40 * vco_p) @(posedge ref_clk_in);
    chk(8'(np >= 40 / div - 1 && np <= 40 / div + 1), 8'h01);
    chk(8'(nb >= np / 2 - 1 && nb <= np / 2 + 1), 8'h01);
  endtask : rate
  task drop(input logic ps, input logic q);
    int i;
    vco_p = 40;
    @(posedge ref_clk_in);
    pseudo_stop_in <= ps;
    for (i = 0; i < 2000 && lock_out !== 1'b0; i++) begin
      @(negedge ref_clk_in);
    end
    if (i == 2000) begin
      errors++;
      results();
    end
    chk(8'(osc_qualified_out), 8'(q));
    vco_p = 20;
    @(posedge ref_clk_in);
    pseudo_stop_in <= 1'b0;
    wlk(1'b1);
  endtask : drop

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    wr(8'h3b, 8'hff);
    rdc(8'h3b, 8'h00);
    rdc(PCF_OFS_REF_DIVIDER_VALUE, PCF_RST_REF_DIVIDER_VALUE);
    rdc(PCF_OFS_FLAGS, 8'h60);
    rdc(PCF_OFS_CLKSEL, 8'h80);
    m_e = PCF_RST_MULT;
    r_e = PCF_RST_REF_DIVIDER_VALUE;
    p_e = 8'(PCF_RST_POST_DIVIDER_VALUE);
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      wr(PCF_OFS_WRITE_PROTECT_BIT, {7'h00, r[24]});
      wr(PCF_OFS_MULT, {1'b0, r[6:0]});
      wr(PCF_OFS_REF_DIVIDER_VALUE, r[15:8]);
      wr(PCF_OFS_POST_DIVIDER_VALUE, r[23:16]);
      m_e = upd(m_e, {1'b0, r[6:0]}, 8'hff, !r[24]);
      r_e = upd(r_e, r[15:8], 8'hcf, !r[24]);
      p_e = upd(p_e, r[23:16], 8'h1f, 1'b1);
      rdc(PCF_OFS_MULT, m_e);
      rdc(PCF_OFS_REF_DIVIDER_VALUE, r_e);
      rdc(PCF_OFS_POST_DIVIDER_VALUE, p_e);
    end
    chk(8'(ref_range_sel_out), 8'h00);
    wr(PCF_OFS_FLAGS, 8'h00);
    rdc(PCF_OFS_FLAGS, 8'h60);
    wr(PCF_OFS_FLAGS, 8'h40);
    rdc(PCF_OFS_FLAGS, 8'h20);
    ev(5'h01);
    ev(5'h10);
    rdc(PCF_OFS_FLAGS, 8'h24);
    rdc(PCF_OFS_POST_DIVIDER_VALUE, 8'(PCF_RST_POST_DIVIDER_VALUE));
    wr(PCF_OFS_FLAGS, 8'hff);
    ev(5'h02);
    rdc(PCF_OFS_FLAGS, 8'h20);
    wr(PCF_OFS_FLAGS, 8'h20);
    ev(5'h04);
    rdc(PCF_OFS_FLAGS, 8'h80);
    wr(PCF_OFS_CLKSEL, 8'h00);
    rdc(PCF_OFS_CLKSEL, 8'h80);
    vco_p = 50;
    wlk(1'b0);
    wr(PCF_OFS_FLAGS, 8'h08);
    rdc(PCF_OFS_FLAGS, 8'h18, 8'h18);
    wr(PCF_OFS_POST_DIVIDER_VALUE, 8'h01);
    rate(2);
    wr(PCF_OFS_MULT, 8'h01);
    rate(4);
    chk(8'(lock_out), 8'h00);
    vco_p = 25;
    wlk(1'b0);
    wr(PCF_OFS_REF_DIVIDER_VALUE, 8'h40);
    @(posedge ref_clk_in);
    ext_osc_enable_in <= 1'b1;
    osc_p = 40;
    vco_p = 20;
    wr(PCF_OFS_MULT, 8'h00);
    wlk(1'b1);
    chk(8'(ref_range_sel_out), 8'h01);
    drop(1'b1, 1'b1);
    drop(1'b0, 1'b0);
    nc = 0;
    repeat (200) @(posedge ref_clk_in);
    chk(8'(nc > 0), 8'h01);
    wr(PCF_OFS_CLKSEL, 8'h00);
    rdc(PCF_OFS_CLKSEL, 8'h00);
    wr(PCF_OFS_POST_DIVIDER_VALUE, 8'h07);
    rdc(PCF_OFS_POST_DIVIDER_VALUE, 8'h01);
    wr(PCF_OFS_MULT, 8'h05);
    rdc(PCF_OFS_MULT, 8'h00);
    osc_p = 0;
    ev(5'h08);
    @(negedge ref_clk_in);
    chk(8'(osc_qualified_out), 8'h00);
    rdc(PCF_OFS_CLKSEL, 8'h80);
    ev(5'h04);
    for (int k = 0; k < 3; k++) begin
      m_e = 8'h80 >> (3 * k);
      wr(PCF_OFS_IRQEN, m_e);
      settle();
      chk(8'(irq_req_out), 8'h01);
      wr(PCF_OFS_FLAGS, m_e);
      settle();
      chk(8'(irq_req_out), 8'h00);
    end
    results();
  end
endmodule : tb
